//--- irqdma_cfg.svh
/*
  Constants of the interrupt controller with micro DMA: channel counts,
  vector numbers, levels, register offsets, field positions and timing.
  Assumes it is included by the package, the controller, the port checker and the bench.
*/
`ifndef IRQDMA_CFG_SVH
`define IRQDMA_CFG_SVH

`define IRQDMA_NUM_CH 24
`define IRQDMA_NUM_DMA 4
`define IRQDMA_NUM_DMA_SRC 18
`define IRQDMA_NUM_PIN_SRC 5
`define IRQDMA_CH_DONE0 18
`define IRQDMA_CH_NMI 22
`define IRQDMA_CH_WDT 23

`define IRQDMA_VEC_PIN_BASE 8'h28
`define IRQDMA_VEC_PER_BASE 8'h40
`define IRQDMA_VEC_DONE_BASE 8'h74
`define IRQDMA_VEC_NMI 8'h20
`define IRQDMA_VEC_WDT 8'h24

`define IRQDMA_LVL_OFF 3'h0
`define IRQDMA_LVL_DMA 3'h6
`define IRQDMA_LVL_NMI 3'h7

`define IRQDMA_OFS_LEVEL 12'h000
`define IRQDMA_OFS_LEVEL_END 12'h060
`define IRQDMA_OFS_SVEC 12'h080
`define IRQDMA_OFS_SVEC_END 12'h090
`define IRQDMA_OFS_DMA 12'h100
`define IRQDMA_OFS_DMA_END 12'h140
`define IRQDMA_OFS_STATUS 12'h140

`define IRQDMA_PEND_BIT 3
`define IRQDMA_SIZE_BYTE 2'h0
`define IRQDMA_SIZE_WORD 2'h1
`define IRQDMA_SIZE_QUAD 2'h2
`define IRQDMA_AMODE_INC 2'h1
`define IRQDMA_AMODE_DEC 2'h2

`define IRQDMA_CLK_NS 40
`define IRQDMA_STATE_NS 80
`define IRQDMA_CLK_PER_STATE ((`IRQDMA_STATE_NS + `IRQDMA_CLK_NS - 1) / `IRQDMA_CLK_NS)
`define IRQDMA_PREF_STATES 3
`define IRQDMA_READ_STATES 2
`define IRQDMA_DUMMY_STATES 1
`define IRQDMA_WRITE_STATES 2
`define IRQDMA_EXTRA_STATES 2

`endif

//--- irqdma_pkg.sv
/*
  Types of the interrupt controller with micro DMA: engine phases and
  the packed state record. Assumes irqdma_cfg.svh is on the include path.
*/
`include "irqdma_cfg.svh"

package irqdma_pkg;

  typedef enum logic [2:0] {PH_IDLE, PH_PREF, PH_READ, PH_DUMMY, PH_WRITE} irqdma_phase_t;

  typedef struct packed {
    logic [`IRQDMA_NUM_CH-1:0] pend;
    logic [`IRQDMA_NUM_CH-1:0][2:0] level;
    logic [`IRQDMA_NUM_DMA-1:0][5:0] svec;
    logic [`IRQDMA_NUM_DMA-1:0][31:0] src;
    logic [`IRQDMA_NUM_DMA-1:0][31:0] dst;
    logic [`IRQDMA_NUM_DMA-1:0][5:0] kind;
    logic [`IRQDMA_NUM_DMA-1:0][15:0] cnt;
    irqdma_phase_t st;
    logic [1:0] ch;
    logic [3:0] tick;
    logic [31:0] data;
    logic req;
    logic [2:0] lvl;
    logic [7:0] vec;
    logic is_dma;
    logic [4:0] win;
    logic [1:0] dch;
    logic wr_pend;
    logic rd_pend;
    logic [11:0] a_addr;
    logic hready;
    logic [31:0] hrdata;
    logic mem_rd;
    logic mem_wr;
    logic [23:0] mem_addr;
    logic [1:0] mem_size;
    logic [31:0] mem_wdata;
  } irqdma_state_t;

endpackage

//--- irqdma_ctrl.sv
/*
  Interrupt controller for 24 channels with a four-channel micro DMA
  engine, register file on an AHB-Lite slave port.
  Assumes one 25 MHz clock, synchronous request inputs, a CPU that takes
  the presented request with a one-cycle irq_ack, and zero-wait memory
  that returns read data on mem_rdata while mem_rd is high.
*/
// Design decisions made here: register access over AHB-Lite and the register offsets.
`include "irqdma_cfg.svh"

// Contract
// - DMA-routed requests are presented at level 6 regardless of programmed level.
// - During CPU standby, DMA requests are not presented and stay pending.
// - Four start-vector registers; matching source vector routes source to that channel.
// - DMA acceptance clears the request, moves one unit, decrements count.
// - Count reaching zero raises done interrupt and clears the start vector.
// - Source whose start vector was cleared is served as an ordinary interrupt.
// - Simultaneous DMA requests: lowest channel number wins, levels ignored.
// - Address registers are 32 bits; only low 24 bits drive the bus.
// - Units of 1, 2 or 4 bytes; each address increments, decrements or stays.
// - Address registers step by the unit size only after the transfer.
// - 16-bit count; initial zero gives 65536 transfers.
// - Only the 18 sources with start vectors can trigger DMA.
// - One transfer: 3 prefetch states, 2 read, 1 dummy, 2 write.
// - Two states more per side for 8-bit bus or odd address.
// - Each of 24 channels has a request flip-flop and a level.
// - Request clears on reset, vector read, DMA accept, or written zero.
// - Reading the clear bit returns the request flip-flop state.
// - Levels 1 to 6 enable; 0 or 7 disable; NMI and watchdog fixed 7.
// - Highest level wins; equal levels go to the smaller vector.
module irqdma_ctrl (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [`IRQDMA_NUM_DMA_SRC-1:0] periph_irq,
  input wire logic nmi_irq,
  input wire logic wdt_irq,
  input wire logic cpu_standby,
  input wire logic irq_ack,
  output logic irq_req,
  output logic [2:0] irq_level,
  output logic [7:0] irq_vector,
  output logic irq_is_dma,
  input wire logic dma_src_bus8,
  input wire logic dma_dst_bus8,
  input wire logic [31:0] mem_rdata,
  output logic mem_rd,
  output logic mem_wr,
  output logic [23:0] mem_addr,
  output logic [1:0] mem_size,
  output logic [31:0] mem_wdata
);

  irqdma_pkg::irqdma_state_t s_q;
  irqdma_pkg::irqdma_state_t s_d;

  logic [`IRQDMA_NUM_CH-1:0] set_req;
  logic [`IRQDMA_NUM_CH-1:0] clr_req;
  logic [`IRQDMA_NUM_CH-1:0] routed;
  logic [`IRQDMA_NUM_DMA-1:0] dma_hit;
  logic [`IRQDMA_NUM_DMA-1:0][4:0] dma_src;
  logic [2:0] best_lvl;
  logic [4:0] best_ch;
  logic dma_any;
  logic [1:0] dma_pick;
  logic [3:0] phase_len;
  logic [31:0] rd_word;

  function automatic logic [7:0] vec_of(input int c);
    if (c < `IRQDMA_NUM_PIN_SRC) begin
      vec_of = `IRQDMA_VEC_PIN_BASE + 8'(4 * c);
    end else if (c < `IRQDMA_CH_DONE0) begin
      vec_of = `IRQDMA_VEC_PER_BASE + 8'(4 * (c - `IRQDMA_NUM_PIN_SRC));
    end else if (c < `IRQDMA_CH_NMI) begin
      vec_of = `IRQDMA_VEC_DONE_BASE + 8'(4 * (c - `IRQDMA_CH_DONE0));
    end else if (c == `IRQDMA_CH_NMI) begin
      vec_of = `IRQDMA_VEC_NMI;
    end else begin
      vec_of = `IRQDMA_VEC_WDT;
    end
  endfunction

  // Non-maskable channels ignore their level field.
  function automatic logic [2:0] eff_level(input int c, input logic [2:0] lv);
    if (c >= `IRQDMA_CH_NMI) begin
      eff_level = `IRQDMA_LVL_NMI;
    end else begin
      eff_level = lv;
    end
  endfunction

  function automatic logic [31:0] step_of(input logic [1:0] size);
    if (size == `IRQDMA_SIZE_WORD) begin
      step_of = 32'h0000_0002;
    end else if (size == `IRQDMA_SIZE_QUAD) begin
      step_of = 32'h0000_0004;
    end else begin
      step_of = 32'h0000_0001;
    end
  endfunction

  function automatic logic [31:0] next_addr(input logic [31:0] a, input logic [1:0] mode,
                                            input logic [31:0] step);
    if (mode == `IRQDMA_AMODE_INC) begin
      next_addr = a + step;
    end else if (mode == `IRQDMA_AMODE_DEC) begin
      next_addr = a - step;
    end else begin
      next_addr = a;
    end
  endfunction

  // Routing and arbitration look only at registered state, so the
  // presented request is stable for the whole cycle the CPU may ack it.
  always_comb begin
    logic [7:0] v;
    logic [2:0] lv;
    v = 8'h00;
    lv = 3'h0;
    routed = '0;
    dma_hit = '0;
    dma_src = '0;
    best_lvl = `IRQDMA_LVL_OFF;
    best_ch = 5'h00;
    dma_any = 1'b0;
    dma_pick = 2'h0;
    for (int n = 0; n < `IRQDMA_NUM_DMA; n++) begin
      for (int c = 0; c < `IRQDMA_NUM_DMA_SRC; c++) begin
        v = vec_of(c);
        if (s_q.svec[n] != 6'h00 && s_q.svec[n] == v[7:2]) begin
          routed[c] = 1'b1;
          if (s_q.pend[c]) begin
            dma_hit[n] = 1'b1;
            dma_src[n] = 5'(c);
          end
        end
      end
    end
    for (int n = `IRQDMA_NUM_DMA - 1; n >= 0; n--) begin
      if (dma_hit[n]) begin
        dma_any = 1'b1;
        dma_pick = 2'(n);
      end
    end
    for (int c = 0; c < `IRQDMA_NUM_CH; c++) begin
      lv = eff_level(c, s_q.level[c]);
      if (s_q.pend[c] && !routed[c] && lv != `IRQDMA_LVL_OFF
          && (lv != `IRQDMA_LVL_NMI || c >= `IRQDMA_CH_NMI) && lv > best_lvl) begin
        best_lvl = lv;
        best_ch = 5'(c);
      end
    end
  end

  // Phase length in clocks; the extra states follow the live address.
  always_comb begin
    phase_len = 4'h1;
    case (s_q.st)
      irqdma_pkg::PH_PREF: begin
        phase_len = 4'(`IRQDMA_PREF_STATES * `IRQDMA_CLK_PER_STATE);
      end
      irqdma_pkg::PH_READ: begin
        if (dma_src_bus8 || s_q.mem_addr[0]) begin
          phase_len = 4'((`IRQDMA_READ_STATES + `IRQDMA_EXTRA_STATES) * `IRQDMA_CLK_PER_STATE);
        end else begin
          phase_len = 4'(`IRQDMA_READ_STATES * `IRQDMA_CLK_PER_STATE);
        end
      end
      irqdma_pkg::PH_DUMMY: begin
        phase_len = 4'(`IRQDMA_DUMMY_STATES * `IRQDMA_CLK_PER_STATE);
      end
      irqdma_pkg::PH_WRITE: begin
        if (dma_dst_bus8 || s_q.mem_addr[0]) begin
          phase_len = 4'((`IRQDMA_WRITE_STATES + `IRQDMA_EXTRA_STATES) * `IRQDMA_CLK_PER_STATE);
        end else begin
          phase_len = 4'(`IRQDMA_WRITE_STATES * `IRQDMA_CLK_PER_STATE);
        end
      end
      default: begin
        phase_len = 4'h1;
      end
    endcase
  end

  // Register read multiplexer; address bits above 11 are not decoded.
  always_comb begin
    logic [11:0] a;
    logic [4:0] idx;
    logic [1:0] dn;
    a = s_q.a_addr;
    idx = a[6:2];
    dn = a[5:4];
    rd_word = 32'h0000_0000;
    if (a >= `IRQDMA_OFS_LEVEL && a < `IRQDMA_OFS_LEVEL_END) begin
      rd_word = {28'h000_0000, s_q.pend[idx], s_q.level[idx]};
    end else if (a >= `IRQDMA_OFS_SVEC && a < `IRQDMA_OFS_SVEC_END) begin
      rd_word = {26'h000_0000, s_q.svec[a[3:2]]};
    end else if (a >= `IRQDMA_OFS_DMA && a < `IRQDMA_OFS_DMA_END) begin
      if (a[3:2] == 2'h0) begin
        rd_word = s_q.src[dn];
      end else if (a[3:2] == 2'h1) begin
        rd_word = s_q.dst[dn];
      end else if (a[3:2] == 2'h2) begin
        rd_word = {26'h000_0000, s_q.kind[dn]};
      end else begin
        rd_word = {16'h0000, s_q.cnt[dn]};
      end
    end else if (a == `IRQDMA_OFS_STATUS) begin
      rd_word = {28'h000_0000, cpu_standby, s_q.ch, s_q.st != irqdma_pkg::PH_IDLE};
    end
  end

  always_comb begin
    logic [11:0] a;
    logic [1:0] c;
    logic [31:0] step;
    logic [15:0] cnt_new;
    s_d = s_q;
    a = s_q.a_addr;
    c = s_q.ch;
    step = 32'h0000_0000;
    cnt_new = 16'h0000;
    clr_req = '0;
    set_req = '0;
    set_req[`IRQDMA_NUM_DMA_SRC-1:0] = periph_irq;
    set_req[`IRQDMA_CH_NMI] = nmi_irq;
    set_req[`IRQDMA_CH_WDT] = wdt_irq;

    // AHB data phase of a write.
    if (s_q.wr_pend) begin
      s_d.wr_pend = 1'b0;
      if (a >= `IRQDMA_OFS_LEVEL && a < `IRQDMA_OFS_LEVEL_END) begin
        s_d.level[a[6:2]] = hwdata[2:0];
        if (!hwdata[`IRQDMA_PEND_BIT]) begin
          clr_req[a[6:2]] = 1'b1;
        end
      end else if (a >= `IRQDMA_OFS_SVEC && a < `IRQDMA_OFS_SVEC_END) begin
        s_d.svec[a[3:2]] = hwdata[5:0];
      end else if (a >= `IRQDMA_OFS_DMA && a < `IRQDMA_OFS_DMA_END) begin
        if (a[3:2] == 2'h0) begin
          s_d.src[a[5:4]] = hwdata;
        end else if (a[3:2] == 2'h1) begin
          s_d.dst[a[5:4]] = hwdata;
        end else if (a[3:2] == 2'h2) begin
          s_d.kind[a[5:4]] = hwdata[5:0];
        end else begin
          s_d.cnt[a[5:4]] = hwdata[15:0];
        end
      end
    end

    // Reads wait one cycle so a write just before is already visible.
    if (s_q.rd_pend) begin
      s_d.rd_pend = 1'b0;
      s_d.hrdata = rd_word;
      s_d.hready = 1'b1;
    end

    // AHB address phase.
    if (hready && hsel && htrans[1]) begin
      s_d.a_addr = haddr[11:0];
      if (hwrite) begin
        s_d.wr_pend = 1'b1;
      end else begin
        s_d.rd_pend = 1'b1;
        s_d.hready = 1'b0;
      end
    end

    // CPU acceptance of the presented request.
    s_d.req = 1'b0;
    if (irq_ack && s_q.req) begin
      clr_req[s_q.win] = 1'b1;
      if (s_q.is_dma) begin
        s_d.st = irqdma_pkg::PH_PREF;
        s_d.tick = 4'h0;
        s_d.ch = s_q.dch;
      end
    end else if (s_q.st == irqdma_pkg::PH_IDLE) begin
      if (dma_any && !cpu_standby && best_lvl != `IRQDMA_LVL_NMI) begin
        s_d.req = 1'b1;
        s_d.lvl = `IRQDMA_LVL_DMA;
        s_d.vec = vec_of(int'(dma_src[dma_pick]));
        s_d.is_dma = 1'b1;
        s_d.win = dma_src[dma_pick];
        s_d.dch = dma_pick;
      end else if (best_lvl != `IRQDMA_LVL_OFF) begin
        s_d.req = 1'b1;
        s_d.lvl = best_lvl;
        s_d.vec = vec_of(int'(best_ch));
        s_d.is_dma = 1'b0;
        s_d.win = best_ch;
      end
    end

    if (s_q.st != irqdma_pkg::PH_IDLE) begin
      if (s_q.tick == phase_len - 4'h1) begin
        s_d.tick = 4'h0;
        case (s_q.st)
          irqdma_pkg::PH_PREF: begin
            s_d.st = irqdma_pkg::PH_READ;
          end
          irqdma_pkg::PH_READ: begin
            s_d.data = mem_rdata;
            s_d.st = irqdma_pkg::PH_DUMMY;
          end
          irqdma_pkg::PH_DUMMY: begin
            s_d.st = irqdma_pkg::PH_WRITE;
          end
          default: begin
            s_d.st = irqdma_pkg::PH_IDLE;
            step = step_of(s_q.kind[c][1:0]);
            s_d.src[c] = next_addr(s_q.src[c], s_q.kind[c][5:4], step);
            s_d.dst[c] = next_addr(s_q.dst[c], s_q.kind[c][3:2], step);
            cnt_new = s_q.cnt[c] - 16'h0001;
            s_d.cnt[c] = cnt_new;
            if (cnt_new == 16'h0000) begin
              set_req[`IRQDMA_CH_DONE0 + int'(c)] = 1'b1;
              s_d.svec[c] = 6'h00;
            end
          end
        endcase
      end else begin
        s_d.tick = s_q.tick + 4'h1;
      end
    end

    s_d.mem_rd = (s_d.st == irqdma_pkg::PH_READ);
    s_d.mem_wr = (s_d.st == irqdma_pkg::PH_WRITE);
    if (s_d.st == irqdma_pkg::PH_WRITE) begin
      s_d.mem_addr = s_d.dst[s_d.ch][23:0];
    end else begin
      s_d.mem_addr = s_d.src[s_d.ch][23:0];
    end
    s_d.mem_size = s_d.kind[s_d.ch][1:0];
    s_d.mem_wdata = s_d.data;

    // A new request in the cycle of its clear is kept: set wins.
    s_d.pend = set_req | (s_q.pend & ~clr_req);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.hready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = s_q.hready;
  assign hresp = 1'b0;
  assign hrdata = s_q.hrdata;
  assign irq_req = s_q.req;
  assign irq_level = s_q.lvl;
  assign irq_vector = s_q.vec;
  assign irq_is_dma = s_q.is_dma;
  assign mem_rd = s_q.mem_rd;
  assign mem_wr = s_q.mem_wr;
  assign mem_addr = s_q.mem_addr;
  assign mem_size = s_q.mem_size;
  assign mem_wdata = s_q.mem_wdata;

endmodule

//--- irqdma_ctrl_props.sv
/*
  Port checker for irqdma_ctrl, attached by bind.
  Assumes the bus-width inputs stay steady while a transfer runs.
*/
`include "irqdma_cfg.svh"

module irqdma_ctrl_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cpu_standby,
  input wire logic irq_ack,
  input wire logic irq_req,
  input wire logic [2:0] irq_level,
  input wire logic [7:0] irq_vector,
  input wire logic irq_is_dma,
  input wire logic dma_src_bus8,
  input wire logic dma_dst_bus8,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [23:0] mem_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  chk_dma_at_six:
    assert property (irq_req && irq_is_dma |-> irq_level == `IRQDMA_LVL_DMA)
    else $error("DMA request shown at wrong level");
  chk_standby_hold:
    assert property ($past(cpu_standby) && $past(cpu_standby, 2) |-> !(irq_req && irq_is_dma))
    else $error("DMA request shown in standby");
  chk_ack_drops:
    assert property (irq_ack && irq_req |=> !irq_req)
    else $error("Request still shown after acceptance");
  chk_fetch_gap:
    assert property (irq_ack && irq_req && irq_is_dma |-> !mem_rd [*7] ##1 mem_rd)
    else $error("Read phase not after the prefetch clocks");
  chk_read_len:
    assert property ($rose(mem_rd) && !dma_src_bus8 && !mem_addr[0] |-> mem_rd [*4] ##1 !mem_rd)
    else $error("Fast read phase length wrong");
  chk_read_slow:
    assert property ($rose(mem_rd) && (dma_src_bus8 || mem_addr[0]) |-> mem_rd [*8] ##1 !mem_rd)
    else $error("Slow read phase length wrong");
  chk_dummy_gap:
    assert property ($fell(mem_rd) |-> !mem_wr [*2] ##1 mem_wr)
    else $error("Dummy state length wrong");
  chk_write_len:
    assert property ($rose(mem_wr) && !dma_dst_bus8 && !mem_addr[0] |-> mem_wr [*4] ##1 !mem_wr)
    else $error("Fast write phase length wrong");
  chk_busy_quiet:
    assert property (mem_rd || mem_wr |-> !irq_req)
    else $error("Request shown during a transfer");
  chk_top_level:
    assert property (irq_req && irq_level == 3'h7 |->
      irq_vector == `IRQDMA_VEC_NMI || irq_vector == `IRQDMA_VEC_WDT)
    else $error("Level 7 on a maskable source");
  chk_no_zero:
    assert property (irq_req |-> irq_level != 3'h0)
    else $error("Disabled level shown");
  chk_addr_hold:
    assert property (mem_rd && $past(mem_rd) |-> $stable(mem_addr))
    else $error("Address moved during read");
endmodule

bind irqdma_ctrl irqdma_ctrl_props chk (.ref_clk, .rst_n, .cpu_standby, .irq_ack, .irq_req,
  .irq_level, .irq_vector, .irq_is_dma, .dma_src_bus8, .dma_dst_bus8, .mem_rd, .mem_wr,
  .mem_addr);

//--- irqdma_cpu_mdl.sv
/*
  CPU and memory model on the far side of the controller.
  Assumes the bench steers acceptance with ack_en and ack_dly.
*/
module irqdma_cpu_mdl (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ack_en,
  input wire logic [3:0] ack_dly,
  input wire logic irq_req,
  input wire logic [2:0] irq_level,
  input wire logic [7:0] irq_vector,
  input wire logic irq_is_dma,
  output logic irq_ack,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [23:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic [7:0] acc_vec,
  output logic [2:0] acc_lvl,
  output logic acc_dma,
  output logic [7:0] acc_cnt,
  output logic [23:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [1:0] wr_size,
  output logic [7:0] wr_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] dly;
  logic [31:0] last_q;
  logic wr_prev;
  // Outside a read the data lines show the inverse of the last cycle's value, so every other cycle they repeat the last read word.
  assign mem_rdata = mem_rd ? {8'hC3, mem_addr} : ~last_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ack <= 1'b0;
      dly <= 4'h0;
      last_q <= 32'h00000000;
      wr_prev <= 1'b0;
      acc_vec <= 8'h00;
      acc_lvl <= 3'h0;
      acc_dma <= 1'b0;
      acc_cnt <= 8'h00;
      wr_addr <= 24'h000000;
      wr_data <= 32'h00000000;
      wr_size <= 2'h0;
      wr_cnt <= 8'h00;
    end else begin
      irq_ack <= 1'b0;
      last_q <= mem_rdata;
      wr_prev <= mem_wr;
      if (irq_ack && irq_req) begin
        acc_vec <= irq_vector;
        acc_lvl <= irq_level;
        acc_dma <= irq_is_dma;
        acc_cnt <= acc_cnt + 8'h01;
        dly <= 4'h0;
      end else if (irq_req && ack_en && !irq_ack) begin
        if (dly >= ack_dly) begin
          irq_ack <= 1'b1;
        end else begin
          dly <= dly + 4'h1;
        end
      end
      if (mem_wr && !wr_prev) begin
        wr_addr <= mem_addr;
        wr_data <= mem_wdata;
        wr_size <= mem_size;
        wr_cnt <= wr_cnt + 8'h01;
      end
    end
  end
endmodule

//--- irqdma_ctrl_tb.sv
/*
  Self-checking bench for irqdma_ctrl over AHB-Lite with a CPU model.
  Assumes a 25 MHz clock and zero-wait memory from the model.
*/
`include "irqdma_cfg.svh"

module irqdma_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, nmi_irq, wdt_irq;
  logic cpu_standby, irq_ack, irq_req, irq_is_dma, dma_src_bus8, dma_dst_bus8;
  logic mem_rd, mem_wr, acc_dma, ack_en;
  logic [31:0] haddr, hwdata, hrdata, mem_rdata, mem_wdata, wr_data, d;
  logic [1:0] htrans, mem_size, wr_size;
  logic [2:0] hsize, irq_level, acc_lvl;
  logic [17:0] periph_irq;
  logic [7:0] irq_vector, acc_vec, acc_cnt, wr_cnt, na, nw;
  logic [23:0] mem_addr, wr_addr;
  logic [3:0] ack_dly;
  int checked, mismatches;
  assign hready = hreadyout;
  irqdma_ctrl uut (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .periph_irq, .nmi_irq, .wdt_irq, .cpu_standby,
    .irq_ack, .irq_req, .irq_level, .irq_vector, .irq_is_dma, .dma_src_bus8, .dma_dst_bus8,
    .mem_rdata, .mem_rd, .mem_wr, .mem_addr, .mem_size, .mem_wdata);
  irqdma_cpu_mdl cpu (.ref_clk, .rst_n, .ack_en, .ack_dly, .irq_req, .irq_level, .irq_vector,
    .irq_is_dma, .irq_ack, .mem_rd, .mem_wr, .mem_addr, .mem_size, .mem_wdata, .mem_rdata,
    .acc_vec, .acc_lvl, .acc_dma, .acc_cnt, .wr_addr, .wr_data, .wr_size, .wr_cnt);
  always #20 ref_clk = ~ref_clk;
  task automatic print_verdict();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic hang();
    mismatches++;
    print_verdict();
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) hang();
      @(posedge ref_clk);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    haddr <= {20'h00000, a};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= v;
    wait_rdy();
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    haddr <= {20'h00000, a};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    wait_rdy();
    chk(hrdata, exp);
  endtask
  task automatic pulse(input logic [17:0] m);
    periph_irq <= m;
    @(posedge ref_clk);
    periph_irq <= 18'h00000;
  endtask
  task automatic wait_acc();
    int n;
    n = 0;
    na = na + 8'h01;
    while (acc_cnt !== na) begin
      @(posedge ref_clk);
      n++;
      if (n > 400) hang();
    end
  endtask
  task automatic wait_wr();
    int n;
    n = 0;
    nw = nw + 8'h01;
    while (wr_cnt !== nw) begin
      @(posedge ref_clk);
      n++;
      if (n > 400) hang();
    end
  endtask
  function automatic logic [11:0] la(input int c);
    return 12'(`IRQDMA_OFS_LEVEL + 4 * c);
  endfunction
  function automatic logic [11:0] sa(input int n);
    return 12'(`IRQDMA_OFS_SVEC + 4 * n);
  endfunction
  function automatic logic [11:0] da(input int n, input int r);
    return 12'(`IRQDMA_OFS_DMA + 16 * n + r);
  endfunction
  initial begin
    {ref_clk, rst_n, hsel, hwrite, nmi_irq, wdt_irq, cpu_standby, ack_en} = 8'h00;
    {dma_src_bus8, dma_dst_bus8, haddr, hwdata, htrans, periph_irq} = 0;
    {hsize, ack_dly, na, nw, checked, mismatches} = 0;
    hsize = 3'h2;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    hsel <= 1'b1;
    for (int i = 0; i < 4; i++) rdc(sa(i), 32'h0);
    rdc(12'h200, 32'h0);
    wr(la(5), 32'h3);
    wr(la(6), 32'h3);
    wr(la(8), 32'h5);
    pulse(18'h001E0);
    repeat (4) @(posedge ref_clk);
    chk(irq_vector, 32'h4C);
    rdc(la(6), 32'hB);
    wr(la(6), 32'h3);
    rdc(la(6), 32'h3);
    ack_en <= 1'b1;
    wait_acc();
    chk(acc_vec, 32'h4C);
    wait_acc();
    chk(acc_vec, 32'h40);
    repeat (10) @(posedge ref_clk);
    chk(irq_req, 32'h0);
    rdc(la(7), 32'h8);
    nmi_irq <= 1'b1;
    wdt_irq <= 1'b1;
    @(posedge ref_clk);
    {nmi_irq, wdt_irq} <= 2'h0;
    wait_acc();
    chk({acc_lvl, acc_vec}, {3'h7, 8'h20});
    wait_acc();
    chk(acc_vec, 32'h24);
    wr(da(1, 0), 32'hFF000100);
    wr(da(1, 4), 32'h200);
    wr(da(1, 8), 32'h1A);
    wr(da(1, 12), 32'h2);
    wr(la(9), 32'h2);
    wr(la(19), 32'h4);
    wr(sa(1), 32'h14);
    for (int k = 0; k < 2; k++) begin
      pulse(18'h00200);
      wait_acc();
      chk({acc_dma, acc_lvl}, {1'b1, 3'h6});
      wait_wr();
      chk(wr_addr, 24'h200 - 4 * k);
      chk(wr_data, {8'hC3, 24'(24'h100 + 4 * k)});
    end
    wait_acc();
    chk({acc_lvl, acc_vec}, {3'h4, 8'h78});
    rdc(sa(1), 32'h0);
    rdc(da(1, 0), 32'hFF000108);
    rdc(da(1, 4), 32'h1F8);
    pulse(18'h00200);
    wait_acc();
    chk({acc_dma, acc_lvl, acc_vec}, {1'b0, 3'h2, 8'h50});
    wr(la(5), 32'h0);
    for (int s = 0; s < 3; s++) begin
      dma_src_bus8 <= (s == 0);
      dma_dst_bus8 <= (s == 1);
      wr(da(0, 0), 32'h1001);
      wr(da(0, 4), 32'h3000);
      wr(da(0, 8), 32'(s) | 32'h10);
      wr(da(0, 12), 32'h1);
      wr(sa(0), 32'h10);
      pulse(18'h00020);
      wait_acc();
      wait_wr();
      chk(wr_size, 32'(s));
      // The address step lands only when the write phase ends, up to eight clocks on.
      repeat (10) @(posedge ref_clk);
      rdc(da(0, 0), 32'h1001 + (32'h1 << s));
      rdc(da(0, 4), 32'h3000);
    end
    ack_dly <= 4'h3;
    for (int c = 2; c < 4; c++) begin
      wr(da(c, 0), 32'h6000);
      wr(da(c, 4), 32'h2000 + 32'h1000 * c);
      wr(da(c, 8), 32'h1);
      wr(da(c, 12), 32'(c - 2) * 3);
      wr(la(8 + c), 32'(2 * c - 3));
      wr(sa(c), 32'(19 + c));
    end
    cpu_standby <= 1'b1;
    pulse(18'h00C00);
    repeat (40) @(posedge ref_clk);
    chk(irq_req, 32'h0);
    chk(wr_cnt, nw);
    cpu_standby <= 1'b0;
    for (int c = 2; c < 4; c++) begin
      wait_acc();
      wait_wr();
      chk(wr_addr, 24'h2000 + 24'h1000 * c);
    end
    rdc(da(2, 12), 32'hFFFF);
    rdc(sa(2), 32'h15);
    print_verdict();
  end
endmodule
